/* File: core/afe_frontend.sv */
// front-end end: samples the sensor, delivers pixels, holds serial settings
// assumes all link inputs arrive asynchronously; the eight control pins pass a 3-flop sync, sensor and serial data two flops
//
// Overview of operation
// - pixel output is unsigned straight binary
// - two-bit code adds 0/4/8/12 ns delay
// - pixel appears six conversion clocks after sampling
// - no conversion clock rise within the inhibit window after ref strobe rise
// - ref then level strobe, never overlapping
// - reference and level sampled on own strobes
// - level strobe times signal capture separately
// - output register clocked by conversion clock
// - serial bit shifted per clock while latch low
// - latch rise moves address and data to latch
// - update pulse makes latched settings take effect
// - standby when all three clocks stopped
// - output bus width per variant, bit0 lsb
// - two independent 8-bit auxiliary converter codes
// - clamp only while dummy clamp and ref strobe
// - black clamp asserted during optical-black pixels
// - reset low returns all settings to default
`timescale 1ns/100ps
module afe_frontend #(
  parameter int PIX_W = afe_pkg::PIX_W,
  parameter int ADDR_W = afe_pkg::SER_ADDR_W,
  parameter int DATA_W = afe_pkg::SER_DATA_W,
  parameter int IDLE_CYC = afe_pkg::IDLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  afe_link_if.frontend link,
  output logic [afe_pkg::DAC_W-1:0] auxDacAOut,
  output logic [afe_pkg::DAC_W-1:0] auxDacBOut,
  output logic clampActive,
  output logic blackLoopCap,
  output logic standby,
  output logic [1:0] delayCode
);
  import afe_pkg::*;

  localparam int NSYNC = 8;
  localparam int LEN = ADDR_W + DATA_W;
  localparam int IDLE_W = $clog2(IDLE_CYC + 1);
  // pin idle levels (only the serial latch idles high): a sync reset to anything
  // else would show a false edge to the edge detectors just after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 8'h04;

  logic [NSYNC-1:0] s1Ff, s2Ff, s3Ff, stableFf;
  logic [NSYNC-1:0] raw;
  assign raw = {link.refSampleStrobe, link.levelSampleStrobe, link.convOutClk,
                link.dummyClampIn, link.blackClampIn, link.serLatchN,
                link.serClk, link.serUpdate};

  // change accepted only once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1Ff <= SYNC_IDLE;
      s2Ff <= SYNC_IDLE;
      s3Ff <= SYNC_IDLE;
      stableFf <= SYNC_IDLE;
    end else begin
      s1Ff <= raw;
      s2Ff <= s1Ff;
      s3Ff <= s2Ff;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2Ff[i] == s3Ff[i]) begin
          stableFf[i] <= s3Ff[i];
        end
      end
    end
  end

  logic refS, lvlS, convS, dumS, blkS, latchNS, sckS, updS;
  assign {refS, lvlS, convS, dumS, blkS, latchNS, sckS, updS} = stableFf;
  logic [NSYNC-1:0] prevFf;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevFf <= SYNC_IDLE;
    end else begin
      prevFf <= stableFf;
    end
  end
  logic refRise, lvlRise, convRise, latchRise, sckRise, updRise;
  assign refRise = refS & ~prevFf[7];
  assign lvlRise = lvlS & ~prevFf[6];
  assign convRise = convS & ~prevFf[5];
  assign latchRise = latchNS & ~prevFf[2];
  assign sckRise = sckS & ~prevFf[1];
  assign updRise = updS & ~prevFf[0];

  // sensor data is a bus: sample two flops deep, only read on strobe edges
  logic [PIX_W-1:0] senA, senB, refLevelFf, sigLevelFf;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      senA <= '0;
      senB <= '0;
    end else begin
      senA <= link.sensorIn;
      senB <= senA;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refLevelFf <= '0;
    end else if (refRise) begin
      refLevelFf <= senB;
    end
  end

  logic newPixFf;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sigLevelFf <= '0;
      newPixFf <= 1'b0;
    end else begin
      newPixFf <= lvlRise;
      if (lvlRise) begin
        sigLevelFf <= senB;
      end
    end
  end

  // straight binary difference, floored at zero
  logic [PIX_W-1:0] pixCode;
  assign pixCode = (sigLevelFf >= refLevelFf) ? PIX_W'(sigLevelFf - refLevelFf) : '0;

  // two-entry buffer: a pixel waits here until the conversion clock takes it
  logic [PIX_W-1:0] bufMem [2];
  logic [1:0] bufCnt;
  logic bufWp, bufRp;
  logic bufInValid, bufInReady, bufOutValid, bufOutReady;
  assign bufInValid = newPixFf;
  assign bufInReady = (bufCnt != 2'd2);
  assign bufOutValid = (bufCnt != 2'd0);

  logic [PIX_W-1:0] pipeFf [LATENCY_CLKS];
  assign bufOutReady = convRise;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bufCnt <= '0;
      bufWp <= 1'b0;
      bufRp <= 1'b0;
      bufMem[0] <= '0;
      bufMem[1] <= '0;
    end else begin
      if (bufInValid && bufInReady) begin
        bufMem[bufWp] <= pixCode;
        bufWp <= ~bufWp;
      end
      if (bufOutValid && bufOutReady) begin
        bufRp <= ~bufRp;
      end
      bufCnt <= bufCnt + 2'(bufInValid && bufInReady) - 2'(bufOutValid && bufOutReady);
    end
  end

  // pipeline advances only on the conversion clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < LATENCY_CLKS; i++) begin
        pipeFf[i] <= '0;
      end
    end else if (convRise) begin
      pipeFf[0] <= bufOutValid ? bufMem[bufRp] : pipeFf[0];
      for (int i = 1; i < LATENCY_CLKS; i++) begin
        pipeFf[i] <= pipeFf[i-1];
      end
    end
  end

  // extra delay of code steps, each 2 ns step rounded up to one clock cycle
  localparam int DMAX = 3 * DLY_STEP_CYC;
  logic [PIX_W-1:0] dlyFf [DMAX+1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i <= DMAX; i++) begin
        dlyFf[i] <= '0;
      end
    end else begin
      dlyFf[0] <= pipeFf[LATENCY_CLKS-1];
      for (int i = 1; i <= DMAX; i++) begin
        dlyFf[i] <= dlyFf[i-1];
      end
    end
  end
  // bit 0 is the lsb of the bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.pixOutBit <= '0;
    end else begin
      link.pixOutBit <= dlyFf[int'(delayCode) * DLY_STEP_CYC];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clampActive <= 1'b0;
      blackLoopCap <= 1'b0;
    end else begin
      clampActive <= dumS & refS;
      blackLoopCap <= blkS;
    end
  end

  // standby after all three clocks idle
  logic [IDLE_W-1:0] idleFf;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idleFf <= '0;
      standby <= 1'b0;
    end else begin
      if (refRise || lvlRise || convRise) begin
        idleFf <= '0;
        standby <= 1'b0;
      end else if (idleFf == IDLE_W'(IDLE_CYC)) begin
        standby <= 1'b1;
      end else begin
        idleFf <= idleFf + 1'b1;
      end
    end
  end

  // shift on serial clock rise while latch low
  // frame widths are parameters, msb first
  logic [LEN-1:0] shiftFf, latchFf;
  logic serDinA, serDinB;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serDinA <= 1'b0;
      serDinB <= 1'b0;
      shiftFf <= '0;
    end else begin
      serDinA <= link.serDin;
      serDinB <= serDinA;
      if (sckRise && !latchNS) begin
        shiftFf <= {shiftFf[LEN-2:0], serDinB};
      end
    end
  end

  // latch on rise of the load strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latchFf <= '0;
    end else if (latchRise) begin
      latchFf <= shiftFf;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      delayCode <= DELAY_RST;
      auxDacAOut <= DAC_RST;
      auxDacBOut <= DAC_RST;
    end else if (updRise) begin
      case (latchFf[LEN-1 -: ADDR_W])
        ADDR_DELAY: delayCode <= latchFf[1:0];
        ADDR_DAC_A: auxDacAOut <= latchFf[DAC_W-1:0];
        ADDR_DAC_B: auxDacBOut <= latchFf[DAC_W-1:0];
        default: delayCode <= delayCode;
      endcase
    end
  end
endmodule

/* File: pkg/afe_pkg.sv */
// shared constants and types for the sensor front-end digital link
// assumes both ends run on one 250 MHz clock with active-low async reset
package afe_pkg;
  localparam int PIX_W = 16;
  localparam int CLK_PERIOD_NS = 4;
  // extra output delay steps, in ns, per two-bit code
  localparam int DLY_STEP_NS = 2;
  localparam int DLY_STEP_CYC = (DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATENCY_CLKS = 6;
  // strobe gap and width, ns
  localparam int STROBE_NS = 7;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // inhibit window after ref strobe rise, ns
  localparam int INHIBIT_NS = 10;
  localparam int INHIBIT_CYC = (INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // serial clock half period, ns (min 25)
  localparam int SCK_HALF_NS = 28;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SER_ADDR_W = 4;
  localparam int SER_DATA_W = 12;
  localparam int SER_LEN = SER_ADDR_W + SER_DATA_W;
  localparam int DAC_W = 8;
  localparam int IDLE_CYC = 64;
  // register addresses inside the serial frame
  localparam logic [SER_ADDR_W-1:0] ADDR_DELAY = 4'h1;
  localparam logic [SER_ADDR_W-1:0] ADDR_DAC_A = 4'h2;
  localparam logic [SER_ADDR_W-1:0] ADDR_DAC_B = 4'h3;
  localparam logic [1:0] DELAY_RST = 2'h0;
  localparam logic [DAC_W-1:0] DAC_RST = 8'h00;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_REF = 2'b01, PH_GAP = 2'b10, PH_LVL = 2'b11
  } pix_phase_type;
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00, SR_LOW = 2'b01, SR_HIGH = 2'b10, SR_DONE = 2'b11
  } ser_state_type;
endpackage

/* File: pkg/afe_link_if.sv */
// link between the timing/processor end and the front-end end
// the testbench instantiates it and feeds clk and resetn to both ends
`timescale 1ns/100ps
interface afe_link_if;
  logic refSampleStrobe;
  logic levelSampleStrobe;
  logic convOutClk;
  logic dummyClampIn;
  logic blackClampIn;
  logic preblankIn;
  logic serLatchN;
  logic serClk;
  logic serDin;
  logic serUpdate;
  logic [afe_pkg::PIX_W-1:0] pixOutBit;
  logic [afe_pkg::PIX_W-1:0] sensorIn;
  modport frontend (
    input refSampleStrobe, levelSampleStrobe, convOutClk, dummyClampIn,
    input blackClampIn, preblankIn, serLatchN, serClk, serDin, serUpdate, sensorIn,
    output pixOutBit
  );
  modport timing (
    output refSampleStrobe, levelSampleStrobe, convOutClk, dummyClampIn,
    output blackClampIn, preblankIn, serLatchN, serClk, serDin, serUpdate, sensorIn,
    input pixOutBit
  );
endinterface

/* File: core/afe_timing.sv */
// timing-generator end: makes strobes, conversion clock, serial writes
// assumes the frontend end samples everything through its own synchronisers
`timescale 1ns/100ps
module afe_timing #(
  parameter int ADDR_W = afe_pkg::SER_ADDR_W,
  parameter int DATA_W = afe_pkg::SER_DATA_W
) (
  input wire logic clk,
  input wire logic resetn,
  afe_link_if.timing link,
  input wire logic run,
  input wire logic dummyClamp,
  input wire logic blackClamp,
  input wire logic [afe_pkg::PIX_W-1:0] sensorLevel,
  input wire logic cmdValid,
  input wire logic [afe_pkg::SER_ADDR_W-1:0] cmdAddr,
  input wire logic [afe_pkg::SER_DATA_W-1:0] cmdData,
  output logic cmdReady,
  output logic [afe_pkg::PIX_W-1:0] pixData,
  output logic pixValid
);
  import afe_pkg::*;

  localparam int LEN = ADDR_W + DATA_W;
  localparam int PH_W = 4;

  // one pixel period: ref strobe, gap, level strobe, gap
  pix_phase_type phFf;
  logic [PH_W-1:0] phCnt;
  logic [PH_W-1:0] convCnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phFf <= PH_IDLE;
      phCnt <= '0;
    end else if (phCnt != '0) begin
      phCnt <= phCnt - 1'b1;
    end else begin
      phCnt <= PH_W'(STROBE_CYC - 1);
      case (phFf)
        PH_IDLE: phFf <= run ? PH_REF : PH_IDLE;
        PH_REF: phFf <= PH_GAP;
        PH_GAP: phFf <= PH_LVL;
        // idle doubles as the gap after the level strobe
        PH_LVL: phFf <= PH_IDLE;
        default: phFf <= PH_IDLE;
      endcase
    end
  end

  // clamp inputs pass through from the sequencer user side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.refSampleStrobe <= 1'b0;
      link.levelSampleStrobe <= 1'b0;
      link.dummyClampIn <= 1'b0;
      link.blackClampIn <= 1'b0;
      link.preblankIn <= 1'b0;
      link.sensorIn <= '0;
    end else begin
      link.refSampleStrobe <= (phFf == PH_REF);
      link.levelSampleStrobe <= (phFf == PH_LVL);
      link.dummyClampIn <= dummyClamp;
      link.blackClampIn <= blackClamp;
      link.preblankIn <= 1'b0;
      link.sensorIn <= sensorLevel;
    end
  end

  // conversion clock rises only past the inhibit window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      convCnt <= '0;
      link.convOutClk <= 1'b0;
    end else if (phFf == PH_REF && phCnt == PH_W'(STROBE_CYC - 1)) begin
      convCnt <= PH_W'(INHIBIT_CYC);
      link.convOutClk <= 1'b0;
    end else if (convCnt != '0) begin
      convCnt <= convCnt - 1'b1;
      link.convOutClk <= (convCnt == PH_W'(1));
    end
  end

  // word taken once per period, at the start of the ref strobe, where the bus has
  // settled for every delay code; the bus carries no valid, so a shift register
  // counts sampled pixels through the far end's conversion pipeline plus its buffer
  logic tickNow;
  logic sampledFf;
  logic [LATENCY_CLKS:0] inFlightFf;
  assign tickNow = (phFf == PH_REF) && (phCnt == PH_W'(STROBE_CYC - 1));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pixData <= '0;
      pixValid <= 1'b0;
      sampledFf <= 1'b0;
      inFlightFf <= '0;
    end else begin
      pixValid <= 1'b0;
      if (tickNow && link.convOutClk) begin
        pixValid <= inFlightFf[LATENCY_CLKS];
        pixData <= link.pixOutBit;
        inFlightFf <= {inFlightFf[LATENCY_CLKS-1:0], sampledFf};
        sampledFf <= link.levelSampleStrobe;
      end else if (link.levelSampleStrobe) begin
        sampledFf <= 1'b1;
      end
    end
  end

  // data set while latch low, msb first
  // update pulse after the final serial clock
  ser_state_type srFf;
  logic [LEN-1:0] frameFf;
  logic [$clog2(LEN+1)-1:0] bitCnt;
  logic [PH_W-1:0] sckCnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srFf <= SR_IDLE;
      frameFf <= '0;
      bitCnt <= '0;
      sckCnt <= '0;
      cmdReady <= 1'b1;
      link.serLatchN <= 1'b1;
      link.serClk <= 1'b0;
      link.serDin <= 1'b0;
      link.serUpdate <= 1'b0;
    end else if (sckCnt != '0) begin
      sckCnt <= sckCnt - 1'b1;
    end else begin
      sckCnt <= PH_W'(SCK_HALF_CYC);
      case (srFf)
        SR_IDLE: begin
          link.serUpdate <= 1'b0;
          if (cmdValid && cmdReady) begin
            frameFf <= {cmdAddr, cmdData};
            bitCnt <= '0;
            cmdReady <= 1'b0;
            link.serLatchN <= 1'b0;
            srFf <= SR_LOW;
          end else begin
            cmdReady <= 1'b1;
          end
        end
        SR_LOW: begin
          link.serClk <= 1'b0;
          link.serDin <= frameFf[LEN-1];
          frameFf <= {frameFf[LEN-2:0], 1'b0};
          srFf <= SR_HIGH;
        end
        SR_HIGH: begin
          link.serClk <= 1'b1;
          bitCnt <= bitCnt + 1'b1;
          srFf <= (bitCnt == ($bits(bitCnt))'(LEN - 1)) ? SR_DONE : SR_LOW;
        end
        SR_DONE: begin
          if (link.serLatchN) begin
            link.serUpdate <= 1'b1;
            srFf <= SR_IDLE;
          end else begin
            link.serClk <= 1'b0;
            link.serLatchN <= 1'b1;
          end
        end
        default: srFf <= SR_IDLE;
      endcase
    end
  end
endmodule

/* File: verification/afe_link_chk.sv */
// wire checks on the link joining the two front-end ends
// assumes one clock domain; the testbench instantiates it beside the link
`timescale 1ns/100ps
module afe_link_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic refSampleStrobe,
  input wire logic levelSampleStrobe,
  input wire logic convOutClk,
  input wire logic serLatchN,
  input wire logic serClk,
  input wire logic serUpdate
);
  import afe_pkg::*;
  logic [7:0] bitCnt_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // serial clock rises inside the current frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_ff <= '0;
    end else if (serLatchN) begin
      bitCnt_ff <= '0;
    end else if ($rose(serClk)) begin
      bitCnt_ff <= bitCnt_ff + 8'h01;
    end
  end
  a_strobe_exclusive: assert property (!(refSampleStrobe && levelSampleStrobe))
    else $error("strobes overlap");
  a_ref_gap: assert property ($fell(refSampleStrobe) |-> (!levelSampleStrobe)[*2])
    else $error("level strobe too soon");
  a_level_gap: assert property ($fell(levelSampleStrobe) |-> (!refSampleStrobe)[*2])
    else $error("ref strobe too soon");
  a_ref_width: assert property ($rose(refSampleStrobe) |-> refSampleStrobe[*2])
    else $error("ref strobe too short");
  a_inhibit_window: assert property ($rose(refSampleStrobe) |-> (!$rose(convOutClk))[*3])
    else $error("conversion clock edge in inhibit window");
  a_shift_in_frame: assert property ($rose(serClk) |-> !serLatchN)
    else $error("serial clock outside frame");
  a_frame_length: assert property ($rose(serLatchN) |-> bitCnt_ff == 8'(SER_LEN))
    else $error("serial frame length wrong");
  a_update_follows: assert property ($rose(serLatchN) |-> ##[1:40] $rose(serUpdate))
    else $error("no update after frame");
  a_update_width: assert property ($rose(serUpdate) |-> serLatchN throughout serUpdate[*5])
    else $error("update pulse short or inside frame");
endmodule

/* File: verification/testbench.sv */
// self-checking bench: timing end and front-end end joined by the link
// assumes afe_pkg, afe_link_if, both ends and the checker are compiled first
`timescale 1ns/100ps
module testbench;
  import afe_pkg::*;
  localparam int SIM_IDLE = 16;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic dummyClamp = 1'b0;
  logic blackClamp = 1'b0;
  logic [PIX_W-1:0] sensorLevel = '0;
  logic cmdValid = 1'b0;
  logic [SER_ADDR_W-1:0] cmdAddr = '0;
  logic [SER_DATA_W-1:0] cmdData = '0;
  logic cmdReady, pixValid, clampActive, blackLoopCap, standby;
  logic [PIX_W-1:0] pixData;
  logic [DAC_W-1:0] auxDacAOut, auxDacBOut;
  logic [1:0] delayCode;
  logic [31:0] seed = 32'hf58c;
  logic [PIX_W-1:0] refSeen = '0;
  logic [PIX_W-1:0] lvlSeen = '0;
  logic refQ = 1'b0;
  logic lvlQ = 1'b0;
  logic clampSeen = 1'b0;
  logic [SER_LEN-1:0] serShift = '0;
  logic [SER_LEN-1:0] serExp = '0;
  logic [PIX_W-1:0] expPix[$];
  int refAt = 0;
  logic [PIX_W-1:0] pixPrev = '0;
  int lat[4];
  int cycle = 0;
  int numErrors = 0;
  int compares = 0;

  afe_link_if link();
  afe_timing u_afe_timing (.clk(clk), .resetn(resetn), .link(link), .run(run),
    .dummyClamp(dummyClamp), .blackClamp(blackClamp), .sensorLevel(sensorLevel),
    .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .pixData(pixData), .pixValid(pixValid));
  afe_frontend #(.IDLE_CYC(SIM_IDLE)) u_afe_frontend (.clk(clk), .resetn(resetn),
    .link(link), .auxDacAOut(auxDacAOut), .auxDacBOut(auxDacBOut),
    .clampActive(clampActive), .blackLoopCap(blackLoopCap), .standby(standby),
    .delayCode(delayCode));
  afe_link_chk u_afe_link_chk (.clk(clk), .resetn(resetn),
    .refSampleStrobe(link.refSampleStrobe), .levelSampleStrobe(link.levelSampleStrobe),
    .convOutClk(link.convOutClk), .serLatchN(link.serLatchN), .serClk(link.serClk),
    .serUpdate(link.serUpdate));

  always #2 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic waitReady();
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (cmdReady !== 1'b1) begin
      check("command ready", 32'(cmdReady), 32'h1);
      conclude();
    end
  endtask

  // request held past the taking edge; ready is seen low one edge later
  task automatic serWrite(input logic [SER_ADDR_W-1:0] a, input logic [SER_DATA_W-1:0] d);
    int n;
    waitReady();
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdAddr <= a;
    cmdData <= d;
    serExp <= {a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady === 1'b1 && n < 100);
    if (cmdReady === 1'b1) begin
      check("command taken", 32'(cmdReady), 32'h0);
      conclude();
    end
    cmdValid <= 1'b0;
    waitReady();
    repeat (40) @(posedge clk);
  endtask

  // serial wire: msb-first shift while the latch is low
  always @(posedge link.serClk) begin
    if (!link.serLatchN) begin
      serShift <= {serShift[SER_LEN-2:0], link.serDin};
    end
  end
  always @(posedge link.serUpdate) begin
    check("serial frame", 32'(serShift), 32'(serExp));
  end

  // notes each pixel sampled on the wire; new level only after ref strobe ends
  always @(posedge clk) begin
    cycle <= cycle + 1;
    refQ <= link.refSampleStrobe;
    lvlQ <= link.levelSampleStrobe;
    if (clampActive === 1'b1) clampSeen <= 1'b1;
    if (link.refSampleStrobe) refSeen <= link.sensorIn;
    if (link.levelSampleStrobe) lvlSeen <= link.sensorIn;
    if (refQ && !link.refSampleStrobe) begin
      seed = xs(seed);
      sensorLevel <= seed[PIX_W-1:0];
    end
    if (lvlQ && !link.levelSampleStrobe) begin
      expPix.push_back(lvlSeen > refSeen ? lvlSeen - refSeen : '0);
    end
    // output bus change time, counted from the ref strobe rise
    if (link.refSampleStrobe && !refQ) refAt <= cycle;
    pixPrev <= link.pixOutBit;
    if (resetn && link.pixOutBit !== pixPrev) lat[delayCode] = cycle - refAt;
  end

  always @(posedge clk) begin
    if (pixValid === 1'b1) begin
      if (expPix.size() == 0) begin
        check("pixel count", 32'h1, 32'h0);
      end else begin
        check("pixel", 32'(pixData), 32'(expPix.pop_front()));
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    check("timeout", 32'h1, 32'h0);
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (SIM_IDLE + 12) @(posedge clk);
    check("standby idle", 32'(standby), 32'h1);
    run <= 1'b1;
    blackClamp <= 1'b1;
    clampSeen <= 1'b0;
    repeat (200) @(posedge clk);
    check("standby run", 32'(standby), 32'h0);
    check("black clamp on", 32'(blackLoopCap), 32'h1);
    check("clamp no dummy", 32'(clampSeen), 32'h0);
    dummyClamp <= 1'b1;
    blackClamp <= 1'b0;
    repeat (200) @(posedge clk);
    check("clamp dummy", 32'(clampSeen), 32'h1);
    check("black clamp off", 32'(blackLoopCap), 32'h0);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      serWrite(ADDR_DELAY, {seed[11:2], 2'(k)});
      check("delay code", 32'(delayCode), 32'(k));
      repeat (150) @(posedge clk);
    end
    check("extra delay", 32'(lat[3] - lat[0]), 32'(3 * DLY_STEP_CYC));
    check("delay step", 32'(lat[2] - lat[1]), 32'(DLY_STEP_CYC));
    serWrite(ADDR_DAC_A, 12'hfff);
    serWrite(ADDR_DAC_B, 12'h0a5);
    check("dac a", 32'(auxDacAOut), 32'hff);
    check("dac b", 32'(auxDacBOut), 32'ha5);
    serWrite(4'h5, 12'h0c3);
    serWrite(4'h0, 12'h001);
    check("dac a kept", 32'(auxDacAOut), 32'hff);
    check("dac b kept", 32'(auxDacBOut), 32'ha5);
    check("delay kept", 32'(delayCode), 32'h3);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    check("dac a reset", 32'(auxDacAOut), 32'(DAC_RST));
    check("delay reset", 32'(delayCode), 32'(DELAY_RST));
    repeat (3) @(posedge clk);
    expPix.delete();
    resetn <= 1'b1;
    repeat (300) @(posedge clk);
    conclude();
  end
endmodule
